// *** core/psla_pkg.sv ***
// Shared constants, types and helpers for the programmable logic array.
`default_nettype none
package psla_pkg;

    // Array geometry.
    localparam int NUM_DED_IN = 10;
    localparam int NUM_MC = 8;
    localparam int NUM_ARR_IN = NUM_DED_IN + NUM_MC;
    localparam int NUM_LINES = 2 * NUM_ARR_IN;
    localparam int PT_PER_OUT = 8;
    localparam int PT_PER_MC = PT_PER_OUT + 1;
    localparam int NUM_PT = NUM_MC * PT_PER_MC + 2;
    localparam int PT_PRESET = NUM_MC * PT_PER_MC;
    localparam int PT_CLEAR = PT_PRESET + 1;
    localparam int ADDR_W = 7;
    localparam int CELL_W = 3;

    // Row addresses as seen on the programming and readout ports.
    localparam logic [ADDR_W-1:0] ROW_LAST = 7'h49;

    // Reset (erased) values of the configuration store.
    localparam logic [NUM_LINES-1:0] FUSE_ERASED = {NUM_LINES{1'b1}};
    localparam logic SEC_ERASED = 1'b0;

    // Feedback source of one macrocell.
    typedef enum logic [1:0] {
        PSLA_FB_NONE,
        PSLA_FB_COMB,
        PSLA_FB_REG,
        PSLA_FB_PIN
    } psla_fb_t;

    // Per-macrocell architecture bits.
    typedef struct packed {
        logic registered;
        logic invert;
        psla_fb_t fb_sel;
    } psla_mc_cfg_t;

    localparam psla_mc_cfg_t MC_CFG_ERASED = '{1'b0, 1'b0, PSLA_FB_NONE};

    // Answer of the configuration readout port.
    typedef struct packed {
        logic valid;
        logic refused;
        logic [NUM_LINES-1:0] data;
    } psla_rd_rsp_t;

    // Line 2i carries input i, line 2i+1 its complement.
    function automatic logic [NUM_LINES-1:0] psla_lines(
        input logic [NUM_ARR_IN-1:0] x
    );
        logic [NUM_LINES-1:0] l;
        l = '0;
        for (int i = 0; i < NUM_ARR_IN; i++) begin
            l[2*i] = x[i];
            l[2*i+1] = ~x[i];
        end
        return l;
    endfunction : psla_lines

    // A set row bit is an intact connection; open ones read as true.
    function automatic logic psla_pt_eval(
        input logic [NUM_LINES-1:0] row,
        input logic [NUM_LINES-1:0] lines
    );
        return &(~row | lines);
    endfunction : psla_pt_eval

endpackage : psla_pkg
`default_nettype wire

// *** core/psla_macrocell.sv ***
// One output macrocell: register, output polarity, enable and feedback select.
`timescale 1ns/1ps
`default_nettype none
module psla_macrocell
    import psla_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sum_term,
    input wire logic oe_term,
    input wire logic preset_term,
    input wire logic clear_term,
    input wire psla_mc_cfg_t cfg,
    input wire logic pin_fb,
    output logic pin_o,
    output logic pin_oe,
    output logic fb
);

    logic q_r;
    logic q_nxt;
    logic q_eff;
    logic comb_fb_r;
    logic out_src;

    // Clear beats preset, preset beats the sum; clear also masks at once.
    assign q_nxt = clear_term ? 1'b0 : (preset_term ? 1'b1 : sum_term);
    assign q_eff = q_r & ~clear_term;

    // Power-up reset empties the register just as the clear term does.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_r <= 1'b0;
            comb_fb_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            comb_fb_r <= sum_term;
        end
    end

    // Polarity is applied after the register or the OR gate.
    assign out_src = cfg.registered ? q_eff : sum_term;
    assign pin_o = out_src ^ cfg.invert;
    assign pin_oe = oe_term;

    // The OR-gate feedback is sampled once, which keeps the array free of
    // combinational loops at the cost of one cycle of latency.
    assign fb = (cfg.fb_sel == PSLA_FB_COMB) ? comb_fb_r :
                (cfg.fb_sel == PSLA_FB_REG) ? q_r :
                (cfg.fb_sel == PSLA_FB_PIN) ? pin_fb : 1'b0;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_preset_only;
        preset_term && !clear_term;
    endsequence

    a_clear_wins_now: assert property (clear_term |-> q_eff == 1'b0)
        else $error("Clear term did not force the register low.");
    a_preset_loads_one: assert property (s_preset_only |=> q_r)
        else $error("Preset term did not load a one.");
    a_clear_over_pre: assert property (clear_term && preset_term |=> !q_r)
        else $error("Preset overrode the clear term.");
    a_reg_output: assert property (
        cfg.registered && !clear_term |-> pin_o == (q_r ^ cfg.invert))
        else $error("Registered output does not follow the register.");
    a_reg_feedback: assert property (
        cfg.fb_sel == PSLA_FB_REG && $stable(cfg) |-> fb == q_r)
        else $error("Register feedback does not show the stored value.");
    a_powerup_clear: assert property (!$past(resetn) |-> !q_r)
        else $error("Register was not cleared at power-up.");

endmodule : psla_macrocell
`default_nettype wire

// *** core/psla_array.sv ***
// Top of the programmable sum-of-products array with its configuration store.
//
// Function
// - Eighteen array inputs, eight outputs, eight OR terms plus enable each.
// - Seventy-four product terms fed by thirty-six true/complement lines.
// - Erased array has every connection; programming only removes them.
// - True and complement both connected makes the term false.
// - True and complement both removed makes the input don't-care.
// - A term with all connections removed is true.
// - Each output combinatorial or registered, each optionally inverted.
// - Feedback per cell: OR result, register, pin or none.
// - One shared synchronous preset and one asynchronous clear term.
// - Preset high loads ones into all registers at next rising edge.
// - Clear high forces all registered pin outputs low (high if inverted) without a clock; registers and their feedback clear at the next rising edge.
// - Clear wins over preset when both are high.
// - Power-up clears all registers like the clear term.
// - Security bit set refuses every readout of the configuration.
// - Erase returns security and all configuration to unprogrammed.
`timescale 1ns/1ps
`default_nettype none
module psla_array
    import psla_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [NUM_DED_IN-1:0] in_pin,
    input wire logic [NUM_MC-1:0] io_in,
    output logic [NUM_MC-1:0] io_o,
    output logic [NUM_MC-1:0] io_oe,
    input wire logic prog_wr,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [NUM_LINES-1:0] prog_row,
    input wire logic cfg_wr,
    input wire logic [CELL_W-1:0] cfg_cell,
    input wire psla_mc_cfg_t cfg_data,
    input wire logic sec_set,
    input wire logic erase,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output psla_rd_rsp_t rd_rsp,
    output logic sec_state
);

    // Configuration store: one fuse row per product term.
    logic [NUM_LINES-1:0] fuse_r [0:NUM_PT-1];
    psla_mc_cfg_t mc_cfg_r [0:NUM_MC-1];
    logic sec_r;
    psla_rd_rsp_t rd_rsp_r;

    // Pin synchronisers: three stages, a change is accepted when 2 and 3 agree.
    logic [NUM_ARR_IN-1:0] pin_raw;
    logic [NUM_ARR_IN-1:0] s1_r;
    logic [NUM_ARR_IN-1:0] s2_r;
    logic [NUM_ARR_IN-1:0] s3_r;
    logic [NUM_ARR_IN-1:0] pin_val_r;
    logic [NUM_ARR_IN-1:0] pin_val_nxt;
    logic [NUM_ARR_IN-1:0] s_agree;

    // Array signals.
    logic [NUM_MC-1:0] mc_fb;
    logic [NUM_ARR_IN-1:0] arr_in;
    logic [NUM_LINES-1:0] lines;
    logic [NUM_PT-1:0] pt;
    logic preset_term;
    logic clear_term;

    // Port decode.
    logic prog_hit;
    logic rd_hit;
    logic rd_ok;
    logic rd_refuse;

    // Per-cell views of the terms and the architecture bits, one bit a cell.
    logic [NUM_MC-1:0] sum_vec;
    logic [NUM_MC-1:0] oe_vec;
    logic [NUM_MC-1:0] reg_cells;
    logic [NUM_MC-1:0] inv_cells;
    logic [NUM_MC-1:0] none_cells;
    logic [NUM_MC-1:0] pin_cells;

    // The pins of the I/O cells are sampled too, so pin feedback sees the
    // level on the wire whether this device or another one drives it.
    assign pin_raw = {io_in, in_pin};
    assign s_agree = s2_r ~^ s3_r;
    assign pin_val_nxt = (s_agree & s3_r) | (~s_agree & pin_val_r);

    // Synchroniser chain; stage one is read only by stage two.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_val_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_val_r <= pin_val_nxt;
        end
    end

    // Array inputs: dedicated pins low, macrocell feedback high.
    assign arr_in = {mc_fb, pin_val_r[NUM_DED_IN-1:0]};
    assign lines = psla_lines(arr_in);

    // Every product term is the AND of its still-connected lines.
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PT; gp++) begin : g_pt
            assign pt[gp] = psla_pt_eval(fuse_r[gp], lines);
        end
    endgenerate

    // Shared register control terms sit after the per-cell rows.
    assign preset_term = pt[PT_PRESET];
    assign clear_term = pt[PT_CLEAR];

    // Eight OR terms and one enable term per macrocell.
    genvar gm;
    generate
        for (gm = 0; gm < NUM_MC; gm++) begin : g_mc
            // Named per-cell wires let the checks below see every cell.
            assign sum_vec[gm] = |pt[gm*PT_PER_MC +: PT_PER_OUT];
            assign oe_vec[gm] = pt[gm*PT_PER_MC + PT_PER_OUT];
            assign reg_cells[gm] = mc_cfg_r[gm].registered;
            assign inv_cells[gm] = mc_cfg_r[gm].invert;
            assign none_cells[gm] = mc_cfg_r[gm].fb_sel == PSLA_FB_NONE;
            assign pin_cells[gm] = mc_cfg_r[gm].fb_sel == PSLA_FB_PIN;

            psla_macrocell u_mc (
                .clk(clk),
                .resetn(resetn),
                .sum_term(sum_vec[gm]),
                .oe_term(oe_vec[gm]),
                .preset_term(preset_term),
                .clear_term(clear_term),
                .cfg(mc_cfg_r[gm]),
                .pin_fb(pin_val_r[NUM_DED_IN + gm]),
                .pin_o(io_o[gm]),
                .pin_oe(io_oe[gm]),
                .fb(mc_fb[gm])
            );
        end
    endgenerate

    // Programming and readout decode; rows beyond the last are refused.
    assign prog_hit = prog_wr && (prog_addr <= ROW_LAST);
    assign rd_hit = rd_addr <= ROW_LAST;
    assign rd_ok = rd_req && rd_hit && !sec_r;
    assign rd_refuse = rd_req && !rd_ok;

    // Fuse store. Writes can only open connections, never restore them;
    // only erase or reset brings the row back to all-connected.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_PT; i++) begin
                fuse_r[i] <= FUSE_ERASED;
            end
        end else if (erase) begin
            for (int i = 0; i < NUM_PT; i++) begin
                fuse_r[i] <= FUSE_ERASED;
            end
        end else if (prog_hit) begin
            fuse_r[prog_addr] <= fuse_r[prog_addr] & prog_row;
        end
    end

    // Macrocell architecture bits and the security bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_MC; i++) begin
                mc_cfg_r[i] <= MC_CFG_ERASED;
            end
            sec_r <= SEC_ERASED;
        end else if (erase) begin
            for (int i = 0; i < NUM_MC; i++) begin
                mc_cfg_r[i] <= MC_CFG_ERASED;
            end
            sec_r <= SEC_ERASED;
        end else begin
            if (cfg_wr) begin
                mc_cfg_r[cfg_cell] <= cfg_data;
            end
            if (sec_set) begin
                sec_r <= 1'b1;
            end
        end
    end

    // Readout answers one cycle after the request; a refused read returns
    // zeros so that nothing of the pattern leaks through the data lines.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_rsp_r <= '0;
        end else begin
            rd_rsp_r.valid <= rd_ok;
            rd_rsp_r.refused <= rd_refuse;
            rd_rsp_r.data <= rd_ok ? fuse_r[rd_addr] : '0;
        end
    end

    assign rd_rsp = rd_rsp_r;
    assign sec_state = sec_r;

    // All checks below run on the one clock and sleep during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_secure_read;
        rd_req && sec_r;
    endsequence

    sequence s_open_read;
        rd_req && !sec_r && rd_hit && !erase && !prog_wr;
    endsequence

    a_secure_refuse: assert property (s_secure_read |=>
        rd_rsp.refused && !rd_rsp.valid && rd_rsp.data == '0)
        else $error("Readout was not refused while secured.");
    a_open_readout: assert property (s_open_read |=>
        rd_rsp.valid && rd_rsp.data == $past(fuse_r[rd_addr]))
        else $error("Readout returned the wrong row.");
    a_erase_restores: assert property (erase |=>
        !sec_r && fuse_r[0] == FUSE_ERASED && fuse_r[PT_CLEAR] == FUSE_ERASED)
        else $error("Erase did not restore the configuration.");
    a_prog_opens_only: assert property (prog_hit && !erase |=>
        (fuse_r[$past(prog_addr)] & ~$past(fuse_r[prog_addr])) == '0)
        else $error("Programming restored a connection.");
    a_open_term_true: assert property (
        fuse_r[PT_PRESET] == '0 |-> preset_term)
        else $error("Fully open term is not true.");
    a_both_pol_false: assert property (
        fuse_r[PT_CLEAR][1:0] == 2'h3 |-> !clear_term)
        else $error("Term with both polarities connected is not false.");
    a_clear_all_low: assert property (clear_term |->
        ((io_o ^ inv_cells) & reg_cells) == '0)
        else $error("Clear term left a registered output active.");
    a_enable_follows: assert property (
        io_oe[0] == pt[PT_PER_OUT] && io_oe[NUM_MC-1] ==
        pt[(NUM_MC-1)*PT_PER_MC + PT_PER_OUT])
        else $error("Pin enable does not follow its enable term.");

    // Quiet cycle: the architecture bits and the clear term are idle, so
    // the next cycle shows exactly what the registers took at the edge.
    sequence s_quiet_cfg;
        !cfg_wr && !erase && !clear_term;
    endsequence

    sequence s_preset_edge;
        s_quiet_cfg ##0 preset_term;
    endsequence

    sequence s_plain_edge;
        s_quiet_cfg ##0 !preset_term;
    endsequence

    // Outputs as seen on the pins. A clear that rises in the next cycle
    // masks the registered outputs at once, so it is let through here.
    a_preset_regs: assert property (s_preset_edge |=>
        clear_term || (((io_o ^ ~inv_cells) & reg_cells) == '0))
        else $error("Preset term did not raise every registered output.");
    a_reg_follows: assert property (s_plain_edge |=>
        clear_term ||
        (((io_o ^ inv_cells ^ $past(sum_vec)) & reg_cells) == '0))
        else $error("Registered output does not show the stored sum.");
    a_comb_output: assert property (
        ((io_o ^ inv_cells ^ sum_vec) & ~reg_cells) == '0)
        else $error("Combinatorial output does not show its OR gate.");
    a_cfg_lands: assert property (cfg_wr && !erase |=>
        mc_cfg_r[$past(cfg_cell)] == $past(cfg_data))
        else $error("Architecture write did not land.");

    // Feedback into the array and the pin samples behind it.
    a_fb_none_zero: assert property (
        (mc_fb & none_cells) == '0)
        else $error("A cell without feedback drives the array.");
    a_pin_feedback: assert property (
        ((mc_fb ^ pin_val_r[NUM_ARR_IN-1:NUM_DED_IN]) & pin_cells) == '0)
        else $error("Pin feedback does not show the sampled pin.");
    a_sync_accept: assert property (
        ((pin_val_r ^ $past(pin_val_r)) & ~$past(s_agree)) == '0 &&
        ((pin_val_r ^ $past(s3_r)) & $past(s_agree)) == '0)
        else $error("Pin sample changed without two agreeing stages.");

    // Power-up, security and erase. Reset stands for power-up of a blank
    // device, so it leaves nothing driven and nothing locked.
    a_powerup_blank: assert property (!$past(resetn) |->
        io_o == '0 && io_oe == '0 && !sec_r && rd_rsp == '0)
        else $error("Device was not blank after power-up.");
    a_sec_sets: assert property (sec_set && !erase |=> sec_r)
        else $error("Security setting was not taken.");
    a_sec_sticky: assert property (sec_r && !erase |=> sec_r)
        else $error("Security setting dropped without an erase.");
    a_range_refused: assert property (rd_req && !rd_hit |=>
        rd_rsp.refused && !rd_rsp.valid && rd_rsp.data == '0)
        else $error("Readout beyond the last row was not refused.");
    a_prog_ignored: assert property (
        prog_wr && !prog_hit && !erase |=>
        $stable(fuse_r[0]) && $stable(fuse_r[PT_CLEAR]))
        else $error("Write beyond the last row changed the store.");
    a_erase_cfg: assert property (erase |=>
        mc_cfg_r[0] == MC_CFG_ERASED && mc_cfg_r[NUM_MC-1] == MC_CFG_ERASED
        && fuse_r[PT_PRESET] == FUSE_ERASED)
        else $error("Erase did not restore the architecture bits.");

endmodule : psla_array
`default_nettype wire

// *** tb/psla_pin_model.sv ***
// Surrounding board logic that resolves the eight shared I/O wires.
`timescale 1ns/1ps
`default_nettype none
module psla_pin_model
    import psla_pkg::*;
(
    input wire logic [NUM_MC-1:0] io_o,
    input wire logic [NUM_MC-1:0] io_oe,
    input wire logic [NUM_MC-1:0] ext_en,
    input wire logic [NUM_MC-1:0] ext_v,
    output logic [NUM_MC-1:0] io_in
);
    // The device wins where it drives, the board driver next, and a
    // pull-up holds a wire that nobody drives, so it never floats.
    assign io_in = (io_oe & io_o) | (~io_oe & ext_en & ext_v)
        | (~io_oe & ~ext_en);
endmodule : psla_pin_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the programmable logic array top.
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import psla_pkg::*;
    logic clk, resetn, prog_wr, cfg_wr, sec_set, erase, rd_req, sec_state;
    logic [NUM_DED_IN-1:0] in_pin;
    logic [NUM_MC-1:0] io_in, io_o, io_oe, ext_en, ext_v;
    logic [ADDR_W-1:0] prog_addr, rd_addr;
    logic [NUM_LINES-1:0] prog_row;
    logic [CELL_W-1:0] cfg_cell;
    psla_mc_cfg_t cfg_data;
    psla_rd_rsp_t rd_rsp;
    int n_errors = 0;
    int n_compared = 0;
    localparam logic [NUM_MC-1:0] OE_EXP = 8'hB7;

    psla_array psla_array_inst (.clk(clk), .resetn(resetn), .in_pin(in_pin),
        .io_in(io_in), .io_o(io_o), .io_oe(io_oe), .prog_wr(prog_wr),
        .prog_addr(prog_addr), .prog_row(prog_row), .cfg_wr(cfg_wr),
        .cfg_cell(cfg_cell), .cfg_data(cfg_data), .sec_set(sec_set),
        .erase(erase), .rd_req(rd_req), .rd_addr(rd_addr), .rd_rsp(rd_rsp),
        .sec_state(sec_state));
    psla_pin_model psla_pin_model_inst (.io_o(io_o), .io_oe(io_oe),
        .ext_en(ext_en), .ext_v(ext_v), .io_in(io_in));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Row mask that keeps only the named line connected.
    function automatic logic [NUM_LINES-1:0] keep(input int b);
        logic [NUM_LINES-1:0] k;
        k = '0;
        k[b] = 1'b1;
        return k;
    endfunction : keep

    task automatic prog(input logic [ADDR_W-1:0] a,
                        input logic [NUM_LINES-1:0] r);
        @(posedge clk);
        prog_wr <= 1'b1;
        prog_addr <= a;
        prog_row <= r;
        @(posedge clk);
        prog_wr <= 1'b0;
    endtask : prog

    task automatic cfg(input logic [CELL_W-1:0] c, input psla_mc_cfg_t d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_cell <= c;
        cfg_data <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask : cfg

    task automatic ctl(input logic s, input logic e);
        @(posedge clk);
        sec_set <= s;
        erase <= e;
        @(posedge clk);
        sec_set <= 1'b0;
        erase <= 1'b0;
        #1;
    endtask : ctl

    // The answer stands only in the cycle after the request is taken.
    task automatic rd(input logic [ADDR_W-1:0] a, input psla_rd_rsp_t e);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        `chk("rd_rsp", e, rd_rsp)
    endtask : rd

    // Pin changes need four synchroniser edges plus feedback stages.
    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    task automatic drv(input logic [NUM_DED_IN-1:0] p,
                       input logic [NUM_MC-1:0] x,
                       input logic [NUM_MC-1:0] e);
        @(posedge clk);
        in_pin <= p;
        ext_v <= x;
        settle();
        `chk("io_oe", OE_EXP, io_oe)
        `chk("io_o", e, io_o & OE_EXP)
    endtask : drv

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // A hang far beyond the expected run of under 150 cycles ends the run.
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        {resetn, prog_wr, cfg_wr, sec_set, erase, rd_req} = '0;
        in_pin = '0;
        ext_v = '0;
        ext_en = 8'h08;
        prog_addr = '0;
        rd_addr = '0;
        prog_row = '0;
        cfg_cell = '0;
        cfg_data = MC_CFG_ERASED;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        settle();
        `chk("io_oe", 8'h00, io_oe)
        rd(7'h00, '{1'b1, 1'b0, FUSE_ERASED});
        rd(ROW_LAST, '{1'b1, 1'b0, FUSE_ERASED});
        rd(7'h4A, '{1'b0, 1'b1, 36'h0});
        // Cells 0 and 1 combinatorial, cell 2 registered and inverted.
        prog(7'h00, keep(0));
        prog(7'h08, '0);
        prog(7'h09, keep(0) | keep(1));
        prog(7'h11, '0);
        cfg(3'h2, '{1'b1, 1'b1, PSLA_FB_REG});
        prog(7'h12, keep(2));
        prog(7'h1A, '0);
        prog(7'h48, keep(4));
        prog(7'h49, keep(6));
        // Cells 4, 5 and 7 take pin, register and OR feedback.
        cfg(3'h3, '{1'b0, 1'b0, PSLA_FB_PIN});
        prog(7'h24, keep(26));
        prog(7'h2C, '0);
        prog(7'h2D, keep(24));
        prog(7'h35, '0);
        cfg(3'h6, '{1'b0, 1'b0, PSLA_FB_COMB});
        prog(7'h36, keep(0));
        prog(7'h3F, keep(32));
        prog(7'h47, '0);
        drv(10'h001, 8'h08, 8'h95);
        `chk("io_oe3", 1'b0, io_oe[3])
        drv(10'h000, 8'h00, 8'h04);
        drv(10'h004, 8'h00, 8'h20);
        drv(10'h00C, 8'h00, 8'h04);
        drv(10'h002, 8'h00, 8'h20);
        // Cell 0 combinatorial inverted, then cell 2 registered true.
        cfg(3'h0, '{1'b0, 1'b1, PSLA_FB_NONE});
        drv(10'h002, 8'h00, 8'h21);
        cfg(3'h2, '{1'b1, 1'b0, PSLA_FB_REG});
        drv(10'h002, 8'h00, 8'h25);
        // Reset in mid-run behaves as a fresh power-up.
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        `chk("io_oe", 8'h00, io_oe)
        `chk("io_o", 8'h00, io_o)
        @(posedge clk);
        resetn <= 1'b1;
        prog(7'h00, keep(0));
        rd(7'h00, '{1'b1, 1'b0, keep(0)});
        ctl(1'b1, 1'b0);
        `chk("sec_state", 1'b1, sec_state)
        rd(7'h00, '{1'b0, 1'b1, 36'h0});
        ctl(1'b0, 1'b1);
        `chk("sec_state", 1'b0, sec_state)
        rd(7'h00, '{1'b1, 1'b0, FUSE_ERASED});
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
